// File: pll_freq_pkg.sv
// Package for the PLL frequency configuration block and its host end.
// Assumes one 25 MHz system clock shared by both ends of the link.
package pll_freq_pkg;

   // ----------------------------------------------------------------
   // Field widths
   // ----------------------------------------------------------------
   localparam int unsigned DIV_CODE_W = 4;
   localparam int unsigned FB_INT_W   = 6;
   localparam int unsigned FB_FRAC_W  = 24;
   localparam int unsigned RATIO_W    = 6;

   // ----------------------------------------------------------------
   // Factory defaults held in non-volatile store (plain values)
   // ----------------------------------------------------------------
   localparam logic [3:0]  NVM_DIV_CODE = 4'h0;
   localparam logic [5:0]  NVM_FB_INT   = 6'h1c;
   localparam logic [23:0] NVM_FB_FRAC  = 24'h00_0000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 40;
   localparam int unsigned OE_OFF_MAX_NS  = 100;
   localparam int unsigned OE_ON_MAX_US   = 10;
   // Longest times round down, at least one cycle
   localparam int unsigned OE_OFF_CYCLES  = (OE_OFF_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                            (OE_OFF_MAX_NS / CLK_PERIOD_NS);
   localparam int unsigned OE_ON_CYCLES   = (OE_ON_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned CAL_CYCLES     = 16;
   localparam int unsigned CNT_W          = 9;

   // Divider code to division ratio
   function automatic logic [5:0] div_ratio(input logic [3:0] code);
      logic [5:0] r;
      r = 6'h04;
      unique case (code)
         4'hf: r = 6'd56;
         4'he: r = 6'd48;
         4'hd: r = 6'd40;
         4'hc: r = 6'd32;
         4'hb: r = 6'd28;
         4'ha: r = 6'd24;
         4'h9: r = 6'd20;
         4'h8: r = 6'd16;
         4'h7: r = 6'd14;
         4'h6: r = 6'd12;
         4'h5: r = 6'd10;
         4'h4: r = 6'd8;
         4'h3: r = 6'd7;
         4'h2: r = 6'd6;
         4'h1: r = 6'd5;
         4'h0: r = 6'd4;
      endcase
      return r;
   endfunction : div_ratio

endpackage : pll_freq_pkg

// File: pll_cfg_if.sv
// Interface carrying the configuration link between host and PLL block.
// Assumes both ends run on the same clk_sys.
`timescale 1ns/100ps
`default_nettype none
interface pll_cfg_if;
   logic        wr_div;
   logic        wr_int;
   logic        wr_frac;
   logic [23:0] wr_data;
   logic        recalibrate_apply;
   logic        fine_adjust_apply;
   logic        output_enable;
   logic        busy;
   logic        clock_running;

   modport host (
      output wr_div, wr_int, wr_frac, wr_data,
             recalibrate_apply, fine_adjust_apply, output_enable,
      input  busy, clock_running
   );
   modport device (
      input  wr_div, wr_int, wr_frac, wr_data,
             recalibrate_apply, fine_adjust_apply, output_enable,
      output busy, clock_running
   );
endinterface : pll_cfg_if
`default_nettype wire

// File: pll_cfg_host.sv
// Host end: turns user requests into single-cycle writes and strobes.
// Assumes the device end sits on the same clk_sys.
`timescale 1ns/100ps
`default_nettype none
module pll_cfg_host (
   input  wire logic    clk_sys,
   input  wire logic    reset_n,
   pll_cfg_if.host      link,
   input  wire logic    req_valid,
   input  wire logic [1:0] req_kind,
   input  wire logic [23:0] req_data,
   input  wire logic    oe_request,
   output logic         req_done,
   output logic         device_busy
);
   logic req_done_q, req_done_d;
   logic div_q, int_q, frac_q, rc_q, fa_q, oe_q;
   logic div_d, int_d, frac_d, rc_d, fa_d, oe_d;
   logic [23:0] data_q, data_d;
   logic busy_q, busy_d;

   // ----------------------------------------------------------------
   // Request decode (0 div, 1 int, 2 frac, 3 apply with data[0]=fine)
   // ----------------------------------------------------------------
   always_comb begin
      div_d = 1'b0;
      int_d = 1'b0;
      frac_d = 1'b0;
      rc_d = 1'b0;
      fa_d = 1'b0;
      data_d = data_q;
      req_done_d = 1'b0;
      oe_d = oe_request;
      busy_d = link.busy;
      // Settings must keep VCO in range; caller's duty
      if (req_valid && !link.busy) begin
         req_done_d = 1'b1;
         data_d = req_data;
         unique case (req_kind)
            2'd0: div_d = 1'b1;
            2'd1: int_d = 1'b1;
            2'd2: frac_d = 1'b1;
            2'd3: begin
               rc_d = ~req_data[0];
               fa_d = req_data[0];
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= 1'b0; int_q <= 1'b0; frac_q <= 1'b0;
         rc_q <= 1'b0; fa_q <= 1'b0; oe_q <= 1'b0;
         data_q <= 24'h00_0000; req_done_q <= 1'b0; busy_q <= 1'b0;
      end else begin
         div_q <= div_d; int_q <= int_d; frac_q <= frac_d;
         rc_q <= rc_d; fa_q <= fa_d; oe_q <= oe_d;
         data_q <= data_d; req_done_q <= req_done_d; busy_q <= busy_d;
      end
   end

   // Downstream may need reset after recalibration
   assign device_busy        = busy_q;
   assign req_done           = req_done_q;
   assign link.wr_div        = div_q;
   assign link.wr_int        = int_q;
   assign link.wr_frac       = frac_q;
   assign link.wr_data       = data_q;
   assign link.recalibrate_apply = rc_q;
   assign link.fine_adjust_apply = fa_q;
   assign link.output_enable = oe_q;
endmodule : pll_cfg_host
`default_nettype wire

// File: pll_frequency_config.sv
// Device end: user and PLL register sets, apply strobes, output gating.
// Assumes host drives the link from the same clk_sys.
// Assumes the analog loop takes the PLL fields as static levels between
// applies, and that nothing but a reset restores the factory defaults.
// Divide ratio, enable and negative leg lag the fields by one register.
`timescale 1ns/100ps
`default_nettype none
module pll_frequency_config (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   pll_cfg_if.device        link,
   output logic [3:0]       output_divider_code,
   output logic [5:0]       feedback_integer,
   output logic [23:0]      feedback_fraction,
   output logic [5:0]       divide_ratio,
   output logic             clock_out_enable,
   output logic             clock_out_neg
);
   // ----------------------------------------------------------------
   // Sequencer state and storage
   // ----------------------------------------------------------------
   // Gray codes: boot -> calibrate -> run -> calibrate, one bit a step
   typedef enum logic [1:0] {
      ST_BOOT = 2'b00,
      ST_CAL  = 2'b01,
      ST_RUN  = 2'b11
   } state_t;

   state_t state_q, state_d;
   // User copy takes host writes; PLL copy is what the loop runs on
   logic [3:0]  user_div_q, user_div_d, pll_div_q, pll_div_d;
   logic [5:0]  user_int_q, user_int_d, pll_int_q, pll_int_d;
   logic [23:0] user_frac_q, user_frac_d, pll_frac_q, pll_frac_d;
   logic [5:0]  ratio_q, ratio_d;
   // Timers count down to zero; nine bits cover the long enable wait
   logic [pll_freq_pkg::CNT_W-1:0] cal_q, cal_d, oe_cnt_q, oe_cnt_d;
   logic        run_q, run_d, en_q, en_d, busy_q, busy_d, neg_q, neg_d;

   // Shared down-count for the calibration and enable timers
   // Callers only step a nonzero count, so it never wraps
   function automatic logic [pll_freq_pkg::CNT_W-1:0] count_down(
      input logic [pll_freq_pkg::CNT_W-1:0] value
   );
      return value - pll_freq_pkg::CNT_W'(1);
   endfunction : count_down

   // ----------------------------------------------------------------
   // Register sets and apply sequencing
   // ----------------------------------------------------------------
   // Next-state: user copy, PLL copy, calibration
   always_comb begin
      state_d = state_q;
      user_div_d = user_div_q;
      user_int_d = user_int_q;
      user_frac_d = user_frac_q;
      pll_div_d = pll_div_q;
      pll_int_d = pll_int_q;
      pll_frac_d = pll_frac_q;
      cal_d = cal_q;
      run_d = run_q;
      busy_d = 1'b0;
      // Writes accepted in any state
      if (link.wr_div)  user_div_d  = link.wr_data[3:0];
      if (link.wr_int)  user_int_d  = link.wr_data[5:0];
      if (link.wr_frac) user_frac_d = link.wr_data;
      unique case (state_q)
         ST_BOOT: begin
            // Entered once after reset, never from the other states
            // Defaults already in user set; now into PLL set
            pll_div_d  = user_div_q;
            pll_int_d  = user_int_q;
            pll_frac_d = user_frac_q;
            cal_d   = pll_freq_pkg::CNT_W'(pll_freq_pkg::CAL_CYCLES);
            run_d   = 1'b0;
            busy_d  = 1'b1;
            state_d = ST_CAL;
         end
         ST_RUN: begin
            // Strobes act once, nothing stored to read back
            // Recalibrate wins when both strobes come in one cycle
            if (link.recalibrate_apply) begin
               pll_div_d  = user_div_q;
               pll_int_d  = user_int_q;
               pll_frac_d = user_frac_q;
               cal_d   = pll_freq_pkg::CNT_W'(pll_freq_pkg::CAL_CYCLES);
               run_d   = 1'b0;          // Clock stopped for calibration
               busy_d  = 1'b1;
               state_d = ST_CAL;
            end else if (link.fine_adjust_apply) begin
               // Divider left alone, clock keeps running
               pll_int_d  = user_int_q;
               pll_frac_d = user_frac_q;
            end
         end
         ST_CAL: begin
            // Holds CAL_CYCLES + 1 cycles; strobes meanwhile are dropped
            busy_d = 1'b1;
            if (cal_q == '0) begin
               run_d   = 1'b1;          // Restart at arbitrary phase
               busy_d  = 1'b0;
               state_d = ST_RUN;
            end else begin
               cal_d = count_down(cal_q);
            end
         end
         default: state_d = ST_BOOT;
      endcase
   end

   // ----------------------------------------------------------------
   // Output gating and divide ratio
   // ----------------------------------------------------------------
   // Fast off, slow on; a stopped loop also drops the output
   always_comb begin
      oe_cnt_d = oe_cnt_q;
      en_d = en_q;
      // Ratio registered, so it follows the code one cycle later
      ratio_d = pll_freq_pkg::div_ratio(pll_div_q);
      if (!link.output_enable || !run_q) begin
         // Off in a single cycle, well under the limit
         en_d = 1'b0;
         // Reload so every turn-on waits the full settling time
         oe_cnt_d = pll_freq_pkg::CNT_W'(pll_freq_pkg::OE_ON_CYCLES - 1);
      end else if (!en_q) begin
         if (oe_cnt_q == '0) en_d = 1'b1;
         else oe_cnt_d = count_down(oe_cnt_q);
      end
      // Negative leg marks idle in step with the enable, not a cycle late
      neg_d = ~en_d;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Power-on loads non-volatile defaults
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_BOOT;
         user_div_q <= pll_freq_pkg::NVM_DIV_CODE;
         user_int_q <= pll_freq_pkg::NVM_FB_INT;
         user_frac_q <= pll_freq_pkg::NVM_FB_FRAC;
         pll_div_q <= pll_freq_pkg::NVM_DIV_CODE;
         pll_int_q <= pll_freq_pkg::NVM_FB_INT;
         pll_frac_q <= pll_freq_pkg::NVM_FB_FRAC;
         cal_q <= '0;
         run_q <= 1'b0;
         busy_q <= 1'b1;
      end else begin
         state_q <= state_d;
         user_div_q <= user_div_d;
         user_int_q <= user_int_d;
         user_frac_q <= user_frac_d;
         pll_div_q <= pll_div_d;
         pll_int_q <= pll_int_d;       // VCO = ref*(int+frac/2^24) downstream
         pll_frac_q <= pll_frac_d;
         cal_q <= cal_d;
         run_q <= run_d;
         busy_q <= busy_d;
      end
   end

   // Gating starts dark: output off and idle until the loop is up
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         oe_cnt_q <= '0;
         en_q <= 1'b0;
         neg_q <= 1'b1;
         ratio_q <= 6'd4;
      end else begin
         oe_cnt_q <= oe_cnt_d;
         en_q <= en_d;
         neg_q <= neg_d;
         ratio_q <= ratio_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, each straight from its register
   // ----------------------------------------------------------------
   assign output_divider_code = pll_div_q;
   assign feedback_integer    = pll_int_q;
   assign feedback_fraction   = pll_frac_q;
   assign divide_ratio        = ratio_q;
   assign clock_out_enable    = en_q;
   assign clock_out_neg       = neg_q;
   // Status back to the host end of the link
   assign link.busy           = busy_q;
   assign link.clock_running  = run_q;
endmodule : pll_frequency_config
`default_nettype wire

// File: pll_cfg_chk.sv
// Checker on the host-to-device configuration link.
// Assumes one clk_sys domain; placed beside the link interface.
`timescale 1ns/100ps
`default_nettype none
module pll_cfg_chk (
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        wr_div,
   input wire logic        wr_int,
   input wire logic        wr_frac,
   input wire logic [23:0] wr_data,
   input wire logic        recalibrate_apply,
   input wire logic        fine_adjust_apply,
   input wire logic        output_enable,
   input wire logic        busy,
   input wire logic        clock_running
);
   // ---------------------------------------------
   // Busy run length, saturating so it cannot wrap
   // ---------------------------------------------
   logic [4:0] busy_run_q, busy_run_d;
   always_comb busy_run_d = !busy ? 5'h00 : (busy_run_q == 5'h1f ? busy_run_q : busy_run_q + 5'h01);
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) busy_run_q <= 5'h00;
      else busy_run_q <= busy_run_d;
   end
   // ---------------------------------------------
   // Link properties
   // ---------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence cal_hold; busy && !clock_running; endsequence
   sequence cal_over; !busy && clock_running; endsequence
   a_recal_stops_clock: assert property (recalibrate_apply && !busy |=> cal_hold[*8] ##[1:20] cal_over)
      else $error("recalibrate did not stop then restart the clock");
   a_fine_keeps_clock: assert property (fine_adjust_apply && !recalibrate_apply && !busy |=> clock_running[*3])
      else $error("fine adjust interrupted the clock");
   a_recal_single_pulse: assert property (recalibrate_apply |=> !recalibrate_apply)
      else $error("recalibrate strobe longer than one cycle");
   a_fine_single_pulse: assert property ($rose(fine_adjust_apply) |=> $fell(fine_adjust_apply))
      else $error("fine adjust strobe longer than one cycle");
   a_run_not_busy: assert property (clock_running |-> !busy)
      else $error("clock running during calibration");
   a_busy_end_runs: assert property ($fell(busy) |-> clock_running)
      else $error("calibration ended without clock");
   a_one_access: assert property ($onehot0({wr_div, wr_int, wr_frac, recalibrate_apply, fine_adjust_apply}))
      else $error("two link accesses in one cycle");
   a_cal_bounded: assert property (busy_run_q <= 5'h14)
      else $error("calibration lasted too long");
endmodule : pll_cfg_chk
`default_nettype wire

// File: test_pll_frequency_config.sv
// Self-checking bench: host end and device end joined by the link.
// Assumes the package, interface and both design modules compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_pll_frequency_config;
   logic        clk_sys, reset_n, req_valid, oe_request, req_done, device_busy;
   logic [1:0]  req_kind;
   logic [23:0] req_data, feedback_fraction;
   logic [3:0]  output_divider_code;
   logic [5:0]  feedback_integer, divide_ratio;
   logic        clock_out_enable, clock_out_neg;
   int          fail_count, samples_checked, n;
   // Ratio expected for each divider code, code 0 first
   localparam logic [5:0] RATIO_TBL [16] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0a, 6'h0c, 6'h0e,
                                             6'h10, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h28, 6'h30, 6'h38};
   // ---------------------------------------------
   // Ends, link and checker
   // ---------------------------------------------
   pll_cfg_if pll_cfg_if_i ();
   pll_cfg_host pll_cfg_host_i (.clk_sys(clk_sys), .reset_n(reset_n), .link(pll_cfg_if_i), .req_valid(req_valid),
      .req_kind(req_kind), .req_data(req_data), .oe_request(oe_request), .req_done(req_done),
      .device_busy(device_busy));
   pll_frequency_config pll_frequency_config_i (.clk_sys(clk_sys), .reset_n(reset_n), .link(pll_cfg_if_i),
      .output_divider_code(output_divider_code), .feedback_integer(feedback_integer),
      .feedback_fraction(feedback_fraction), .divide_ratio(divide_ratio),
      .clock_out_enable(clock_out_enable), .clock_out_neg(clock_out_neg));
   pll_cfg_chk pll_cfg_chk_i (.clk_sys(clk_sys), .reset_n(reset_n), .wr_div(pll_cfg_if_i.wr_div),
      .wr_int(pll_cfg_if_i.wr_int), .wr_frac(pll_cfg_if_i.wr_frac), .wr_data(pll_cfg_if_i.wr_data),
      .recalibrate_apply(pll_cfg_if_i.recalibrate_apply), .fine_adjust_apply(pll_cfg_if_i.fine_adjust_apply),
      .output_enable(pll_cfg_if_i.output_enable), .busy(pll_cfg_if_i.busy),
      .clock_running(pll_cfg_if_i.clock_running));
   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
   endtask : tick
   // Bounded wait for calibration to finish; a hang ends the run
   task automatic wait_idle;
      int k;
      k = 0;
      while (pll_cfg_if_i.busy !== 1'b0) begin
         @(posedge clk_sys);
         k++;
         if (k > 100) begin
            fail_count++;
            close_out();
         end
      end
   endtask : wait_idle
   // One request, valid held for one edge so it is taken once
   task automatic send(input logic [1:0] kind, input logic [23:0] data);
      int k;
      k = 0;
      wait_idle();
      req_kind <= kind;
      req_data <= data;
      req_valid <= 1'b1;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      while (req_done !== 1'b1) begin
         @(posedge clk_sys);
         k++;
         if (k > 8) begin
            fail_count++;
            close_out();
         end
      end
   endtask : send
   // Check the live PLL set against expected fields
   task automatic check_set(input logic [3:0] d, input logic [5:0] i, input logic [23:0] f);
      check(output_divider_code, d);
      check(feedback_integer, i);
      check(feedback_fraction, f);
   endtask : check_set
   // ---------------------------------------------
   // Clock and test sequence
   // ---------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      reset_n = 1'b0;
      req_valid = 1'b0;
      req_kind = 2'h0;
      req_data = 24'h00_0000;
      oe_request = 1'b0;
      fail_count = 0;
      samples_checked = 0;
      tick(5);
      reset_n <= 1'b1;
      wait_idle();
      tick(1);
      check_set(pll_freq_pkg::NVM_DIV_CODE, pll_freq_pkg::NVM_FB_INT, pll_freq_pkg::NVM_FB_FRAC);
      check(divide_ratio, RATIO_TBL[pll_freq_pkg::NVM_DIV_CODE]);
      check(pll_cfg_if_i.clock_running, 1'b1);
      $display("test power-up defaults done");
      // User writes alone must leave the PLL set untouched
      send(2'h0, 24'h00_000a);
      send(2'h1, 24'h00_0019);
      send(2'h2, 24'h3b_2f2c);
      tick(2);
      check_set(pll_freq_pkg::NVM_DIV_CODE, pll_freq_pkg::NVM_FB_INT, pll_freq_pkg::NVM_FB_FRAC);
      send(2'h3, 24'h00_0000);
      tick(1);
      check(pll_cfg_if_i.clock_running, 1'b0);
      tick(1);
      check(device_busy, 1'b1);
      wait_idle();
      tick(1);
      check_set(4'ha, 6'h19, 24'h3b_2f2c);
      check(divide_ratio, 6'h18);
      check(device_busy, 1'b0);
      $display("test recalibrate apply done");
      // Fine adjust moves feedback only, divider stays
      send(2'h0, 24'h00_0003);
      send(2'h1, 24'h00_001a);
      send(2'h2, 24'h00_0010);
      send(2'h3, 24'h00_0001);
      tick(2);
      check(pll_cfg_if_i.clock_running, 1'b1);
      check_set(4'ha, 6'h1a, 24'h00_0010);
      $display("test fine adjust done");
      for (int c = 0; c < 16; c++) begin
         send(2'h0, 24'(c));
         send(2'h3, 24'h00_0000);
         tick(2);
         wait_idle();
         tick(1);
         check(divide_ratio, RATIO_TBL[c]);
      end
      $display("test divider table done");
      // Output enable on within the long bound, off within the short one
      oe_request <= 1'b1;
      n = 0;
      while (clock_out_enable !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      check(32'(n <= pll_freq_pkg::OE_ON_CYCLES + 5), 32'h0000_0001);
      check(clock_out_neg, 1'b0);
      oe_request <= 1'b0;
      tick(pll_freq_pkg::OE_OFF_CYCLES + 1);
      check(clock_out_enable, 1'b0);
      check(clock_out_neg, 1'b1);
      $display("test output enable done");
      // Reset mid-run drops everything written over the link
      reset_n <= 1'b0;
      tick(2);
      reset_n <= 1'b1;
      wait_idle();
      tick(1);
      check_set(pll_freq_pkg::NVM_DIV_CODE, pll_freq_pkg::NVM_FB_INT, pll_freq_pkg::NVM_FB_FRAC);
      $display("test second reset done");
      close_out();
   end
endmodule : test_pll_frequency_config
`default_nettype wire
